// file: include/mic_pkg.sv
// mouse input controller package: timing constants, spi layout, carrier structs
// assumes a 50 MHz system clock
package mic_pkg;

  localparam int unsigned CLK_HZ        = 50_000_000;
  // wheel emitter strobe
  localparam int unsigned EMIT_ON_US    = 40;
  localparam int unsigned EMIT_PER_US   = 2000;
  localparam int unsigned EMIT_ON_CYC   = (CLK_HZ / 1_000_000) * EMIT_ON_US;
  localparam int unsigned EMIT_PER_CYC  = (CLK_HZ / 1_000_000) * EMIT_PER_US;
  // sample point near the end of the on window, after the phototransistors settle
  localparam int unsigned EMIT_SMP_CYC  = EMIT_ON_CYC - 2;
  // button debounce, least time of the 15 to 20 ms band
  localparam int unsigned DEB_MS        = 15;
  localparam int unsigned DEB_CYC       = (CLK_HZ / 1000) * DEB_MS;
  // spi
  localparam int unsigned SPI_HALF_CYC  = 4;
  localparam logic [7:0]  SPI_ADDR_DX   = 8'h03;
  localparam logic [7:0]  SPI_ADDR_DY   = 8'h04;
  localparam int unsigned SPI_BITS      = 8;
  // button indices
  localparam int unsigned BTN_LEFT      = 0;
  localparam int unsigned BTN_WHEEL     = 1;
  localparam int unsigned BTN_RIGHT     = 2;
  localparam int unsigned BTN_NUM       = 3;
  localparam int unsigned WHEEL_W       = 8;

  // one motion report
  typedef struct packed {
    logic [7:0]         dx;
    logic [7:0]         dy;
    logic [WHEEL_W-1:0] wheel;
    logic [2:0]         buttons;
  } mic_report_t;

  // spi master pins
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic sel_n;
  } mic_spi_out_t;

endpackage : mic_pkg

// file: logic/mic_debounce.sv
// one button debouncer: accepts a new level after it has stood stable
// assumes the input has already passed a two-flop synchroniser
`timescale 1ns/1ps
`default_nettype none
module mic_debounce
  import mic_pkg::*;
#(
  parameter int unsigned STABLE_CYC = DEB_CYC
) (
  // clock, reset and enable
  input  wire logic clock,
  input  wire logic srst,
  input  wire logic ce,
  // level in and out
  input  wire logic raw,
  output logic      level
);

  localparam int unsigned CW = $clog2(STABLE_CYC + 1);

  logic [CW-1:0] cnt_q;
  logic          level_q;

  initial begin
    if (STABLE_CYC < 1) $error("mic_debounce: STABLE_CYC must be at least 1");
  end

  // count while the input disagrees; any return to the held level restarts
  always_ff @(posedge clock) begin
    if (srst) begin
      cnt_q   <= '0;
      level_q <= 1'b1;
    end else if (ce) begin
      if (raw == level_q) begin
        cnt_q <= '0;
      end else if (cnt_q == CW'(STABLE_CYC - 1)) begin
        cnt_q   <= '0;
        level_q <= raw;
      end else begin
        cnt_q <= cnt_q + 1'b1;
      end
    end
  end

  assign level = level_q;

endmodule // mic_debounce
`default_nettype wire

// file: logic/mic_input_ctrl.sv
// mouse input controller: wheel emitter strobe and quadrature decode,
// three debounced buttons, motion-alert driven spi read of the sensor
// assumes pins are asynchronous to clock; button pads have pull-ups enabled
`timescale 1ns/1ps
`default_nettype none
module mic_input_ctrl
  import mic_pkg::*;
#(
  parameter int unsigned EMIT_PERIOD = EMIT_PER_CYC,
  parameter int unsigned EMIT_ON     = EMIT_ON_CYC,
  parameter int unsigned DEBOUNCE    = DEB_CYC,
  parameter int unsigned HALF_BIT    = SPI_HALF_CYC
) (
  // clock, reset, enable
  input  wire logic         clock,
  input  wire logic         srst,
  input  wire logic         ce,
  // mode
  input  wire logic         active_mode,
  // wheel encoder
  output logic              wheel_emitter_on,
  input  wire logic         wheel_phase_a,
  input  wire logic         wheel_phase_b,
  // buttons, active low pads
  input  wire logic [2:0]   button_n,
  output logic [2:0]        button_pull_en,
  output logic [2:0]        buttons_pressed,
  // sensor spi and motion alert
  input  wire logic         motion_alert,
  input  wire logic         spi_miso,
  output mic_spi_out_t      spi_out,
  // report out
  output mic_report_t       report,
  output logic              report_valid,
  input  wire logic         report_taken,
  output logic              asleep
);

  initial begin
    if (EMIT_ON < 4 || EMIT_ON >= EMIT_PERIOD) $error("mic_input_ctrl: bad emitter timing");
    // miso passes two sync flops, so a half period must outlast that latency
    if (HALF_BIT < 3) $error("mic_input_ctrl: HALF_BIT must be at least 3");
  end

  localparam int unsigned PW = $clog2(EMIT_PERIOD + 1);
  localparam int unsigned HW = $clog2(HALF_BIT + 1);

  // ---------------- synchronisers for all pins ----------------
  logic [6:0] sync1_q;
  logic [6:0] sync2_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      // idle pin levels: buttons released, no alert, so no false read after reset
      sync1_q <= 7'h70;
      sync2_q <= 7'h70;
    end else if (ce) begin
      sync1_q <= {button_n, spi_miso, motion_alert, wheel_phase_b, wheel_phase_a};
      sync2_q <= sync1_q;
    end
  end
  logic       pha_s;
  logic       phb_s;
  logic       motion_s;
  logic       miso_s;
  logic [2:0] btn_s;
  assign pha_s    = sync2_q[0];
  assign phb_s    = sync2_q[1];
  assign motion_s = sync2_q[2];
  assign miso_s   = sync2_q[3];
  assign btn_s    = sync2_q[6:4];

  // ---------------- wheel emitter strobe ----------------
  logic [PW-1:0] emit_cnt_q;
  logic          emit_q;
  logic          sample_now;
  // free-running period counter; parked on its last count outside active mode,
  // so the led stays dark and the first pulse after enable is full width
  always_ff @(posedge clock) begin
    if (srst) begin
      emit_cnt_q <= PW'(EMIT_PERIOD - 1);
      emit_q     <= 1'b0;
    end else if (ce) begin
      if (!active_mode) begin
        emit_cnt_q <= PW'(EMIT_PERIOD - 1);
        emit_q     <= 1'b0;
      end else begin
        emit_cnt_q <= (emit_cnt_q == PW'(EMIT_PERIOD - 1)) ? '0 : emit_cnt_q + 1'b1;
        emit_q     <= (emit_cnt_q < PW'(EMIT_ON - 1)) || (emit_cnt_q == PW'(EMIT_PERIOD - 1));
      end
    end
  end
  // sample late in the window; the sync delay of two cycles still falls inside it
  assign sample_now = active_mode && emit_q && (emit_cnt_q == PW'(EMIT_ON - 3));

  // ---------------- wheel phase decoder ----------------
  logic [1:0]         phase_q;
  logic               phase_init_q;
  logic [WHEEL_W-1:0] wheel_q;
  logic [1:0]         cur_phase;
  logic               step_fwd;
  logic               step_bwd;
  assign cur_phase = {phb_s, pha_s};
  // gray order 00 -> 01 -> 11 -> 10 is forward
  always_comb begin
    step_fwd = 1'b0;
    step_bwd = 1'b0;
    case ({phase_q, cur_phase})
      4'b0001, 4'b0111, 4'b1110, 4'b1000: step_fwd = 1'b1;
      4'b0010, 4'b1011, 4'b1101, 4'b0100: step_bwd = 1'b1;
      default: begin // no change or both phases changed
        step_fwd = 1'b0;
        step_bwd = 1'b0;
      end
    endcase
  end

  logic report_valid_q;
  logic take_report;
  assign take_report = report_valid_q && report_taken;

  // signed count; a step landing with the clear is kept, not lost
  always_ff @(posedge clock) begin
    if (srst) begin
      phase_q      <= 2'h0;
      phase_init_q <= 1'b0;
      wheel_q      <= '0;
    end else if (ce) begin
      if (sample_now) begin
        phase_q      <= cur_phase;
        phase_init_q <= 1'b1;
      end
      if (take_report) begin
        wheel_q <= (sample_now && phase_init_q && step_fwd) ? WHEEL_W'(1) :
                   (sample_now && phase_init_q && step_bwd) ? {WHEEL_W{1'b1}} : '0;
      end else if (sample_now && phase_init_q && step_fwd) begin
        wheel_q <= wheel_q + 1'b1;
      end else if (sample_now && phase_init_q && step_bwd) begin
        wheel_q <= wheel_q - 1'b1;
      end
    end
  end

  // ---------------- buttons ----------------
  logic [2:0] btn_level;
  genvar gi;
  generate
    for (gi = 0; gi < BTN_NUM; gi++) begin : g_btn
      mic_debounce #(
        .STABLE_CYC (DEBOUNCE)
      ) u_deb (
        .clock (clock),
        .srst  (srst),
        .ce    (ce),
        .raw   (btn_s[gi]),
        .level (btn_level[gi])
      );
    end
  endgenerate

  logic [2:0] pressed_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      pressed_q <= 3'h0;
    end else if (ce) begin
      pressed_q <= ~btn_level;
    end
  end

  // ---------------- spi master for displacement ----------------
  typedef enum logic [2:0] {
    ST_SLEEP = 3'b000,
    ST_ADDR  = 3'b001,
    ST_DATA  = 3'b010,
    ST_GAP   = 3'b011,
    ST_DONE  = 3'b100
  } mic_state_t;

  mic_state_t    state_q;
  logic [HW-1:0] half_q;
  logic [3:0]    bit_q;
  logic          sclk_q;
  logic          sel_n_q;
  logic          mosi_q;
  logic [7:0]    shift_q;
  logic [7:0]    dx_q;
  logic          second_q;
  logic          half_end;
  assign half_end = (half_q == HW'(HALF_BIT - 1));

  // mode 3 style: clock idles high, data changes on falling, sampled on rising
  always_ff @(posedge clock) begin
    if (srst) begin
      state_q  <= ST_SLEEP;
      half_q   <= '0;
      bit_q    <= 4'h0;
      sclk_q   <= 1'b1;
      sel_n_q  <= 1'b1;
      mosi_q   <= 1'b0;
      shift_q  <= 8'h00;
      dx_q     <= 8'h00;
      second_q <= 1'b0;
    end else if (ce) begin
      half_q <= half_end ? '0 : half_q + 1'b1;
      case (state_q)
        ST_SLEEP: begin
          half_q <= '0;
          if (motion_s && !report_valid_q) begin
            state_q  <= ST_ADDR;
            sel_n_q  <= 1'b0;
            shift_q  <= SPI_ADDR_DX;
            bit_q    <= 4'h0;
            second_q <= 1'b0;
          end
        end
        ST_ADDR, ST_DATA: begin
          if (half_end) begin
            sclk_q <= ~sclk_q;
            // mosi moves only on falling, so the sensor never races the shift
            if (sclk_q) begin
              mosi_q <= shift_q[7];
            end
            if (!sclk_q) begin // rising edge: shift in
              shift_q <= {shift_q[6:0], (state_q == ST_DATA) ? miso_s : 1'b0};
              if (bit_q == 4'(SPI_BITS - 1)) begin
                bit_q   <= 4'h0;
                state_q <= (state_q == ST_ADDR) ? ST_DATA : ST_GAP;
              end else begin
                bit_q <= bit_q + 1'b1;
              end
            end
          end
        end
        ST_GAP: begin
          if (half_end) begin
            if (!second_q) begin
              dx_q     <= shift_q;
              shift_q  <= SPI_ADDR_DY;
              second_q <= 1'b1;
              state_q  <= ST_ADDR;
            end else begin
              sel_n_q <= 1'b1;
              state_q <= ST_DONE;
            end
          end
        end
        ST_DONE: state_q <= ST_SLEEP;
        default: state_q <= ST_SLEEP;
      endcase
    end
  end

  // ---------------- report out ----------------
  mic_report_t report_q;
  logic        asleep_q;
  always_ff @(posedge clock) begin
    if (srst) begin
      report_valid_q <= 1'b0;
      report_q       <= '0;
      asleep_q       <= 1'b1;
    end else if (ce) begin
      asleep_q <= (state_q == ST_SLEEP) && !motion_s;
      if (state_q == ST_DONE) begin
        report_valid_q <= 1'b1;
        report_q.dx    <= dx_q;
        report_q.dy    <= shift_q;
      end else if (take_report) begin
        report_valid_q <= 1'b0;
      end
      if (!report_valid_q || take_report) begin
        report_q.wheel   <= wheel_q;
        report_q.buttons <= pressed_q;
      end
    end
  end

  // outputs
  assign wheel_emitter_on = emit_q;
  assign button_pull_en   = 3'h7;
  assign buttons_pressed  = pressed_q;
  assign spi_out          = '{sclk: sclk_q, mosi: mosi_q, sel_n: sel_n_q};
  assign report           = report_q;
  assign report_valid     = report_valid_q;
  assign asleep           = asleep_q;

endmodule // mic_input_ctrl
`default_nettype wire

// file: tb/mic_input_ctrl_assertions.sv
// checker for the mouse input controller: emitter, buttons, spi and report
// assumes it is bound into mic_input_ctrl and sees only its ports
`timescale 1ns/1ps
`default_nettype none
module mic_input_ctrl_chk
  import mic_pkg::*;
#(
  parameter int unsigned EMIT_PERIOD = EMIT_PER_CYC,
  parameter int unsigned EMIT_ON     = EMIT_ON_CYC
) (
  // clock and reset
  input wire logic         clock,
  input wire logic         srst,
  // watched ports
  input wire logic         active_mode,
  input wire logic         wheel_emitter_on,
  input wire logic [2:0]   button_n,
  input wire logic [2:0]   button_pull_en,
  input wire logic [2:0]   buttons_pressed,
  input wire logic         motion_alert,
  input wire mic_spi_out_t spi_out,
  input wire mic_report_t  report,
  input wire logic         report_valid,
  input wire logic         report_taken,
  input wire logic         asleep
);
  logic [31:0] on_q, per_q;
  logic        emit_d, had_q, sclk_d, sel_d;
  logic [5:0]  edg_q;
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // pulse width and spacing; the first pulse after enable has no spacing to judge
  always_ff @(posedge clock) begin
    emit_d <= wheel_emitter_on;
    on_q   <= wheel_emitter_on ? on_q + 32'h1 : 32'h0;
    per_q  <= (wheel_emitter_on && !emit_d) ? 32'h1 : per_q + 32'h1;
    had_q  <= (srst || !active_mode) ? 1'b0 : (had_q || (wheel_emitter_on && !emit_d));
  end
  // clock rising edges per select window
  always_ff @(posedge clock) begin
    sclk_d <= spi_out.sclk;
    sel_d  <= spi_out.sel_n;
    edg_q  <= (!spi_out.sel_n && sel_d) ? 6'h00 : edg_q + 6'(spi_out.sclk && !sclk_d);
  end
  chk_emit_idle: assert property (!active_mode ##1 !active_mode |-> !wheel_emitter_on)
    else $error("emitter on while inactive");
  chk_emit_width: assert property ($fell(wheel_emitter_on) && active_mode && $past(active_mode) |-> on_q == EMIT_ON)
    else $error("emitter pulse width wrong");
  chk_emit_period: assert property (wheel_emitter_on && !emit_d && had_q |-> per_q == EMIT_PERIOD)
    else $error("emitter period wrong");
  chk_pull_on: assert property (button_pull_en == 3'h7)
    else $error("button pull-up off");
  chk_sclk_idle: assert property (spi_out.sel_n |-> spi_out.sclk)
    else $error("serial clock not idle high");
  chk_wake_read: assert property ($rose(motion_alert) && asleep && !report_valid |-> ##[1:4] !spi_out.sel_n)
    else $error("no read after alert");
  chk_pend_idle: assert property (report_valid |-> spi_out.sel_n)
    else $error("read while report pending");
  chk_frame_len: assert property ($rose(report_valid) |-> edg_q == 6'h20)
    else $error("serial clock edge count wrong");
  chk_valid_hold: assert property (report_valid && !report_taken |=> report_valid && $stable(report))
    else $error("report not held");
  chk_take_clear: assert property (report_valid && report_taken |=> !report_valid)
    else $error("report not released");
  chk_btn_debounce: assert property ($changed(buttons_pressed) |-> $past(button_n, 4) == ~buttons_pressed)
    else $error("button change not debounced");
endmodule : mic_input_ctrl_chk
bind mic_input_ctrl mic_input_ctrl_chk #(.EMIT_PERIOD(EMIT_PERIOD), .EMIT_ON(EMIT_ON)) chk_u (
  .clock, .srst, .active_mode, .wheel_emitter_on, .button_n, .button_pull_en, .buttons_pressed,
  .motion_alert, .spi_out, .report, .report_valid, .report_taken, .asleep);
`default_nettype wire

// file: tb/mic_sensor_model.sv
// behavioural navigation sensor on spi, mode 3, msb first
// assumes select stays low across the address and data frames
`timescale 1ns/1ps
`default_nettype none
module mic_sensor_model
  import mic_pkg::*;
(
  // spi pins
  input wire logic       sclk,
  input wire logic       mosi,
  input wire logic       sel_n,
  output var logic       miso,
  // motion source
  input wire logic       moving,
  input wire logic [7:0] dx,
  input wire logic [7:0] dy,
  output logic           motion_alert
);
  logic [7:0] sh, dat;
  int         n = 0;
  // alert follows movement and drops as soon as it stops
  assign motion_alert = moving;
  // address shifted in on rising clock
  always @(posedge sclk or posedge sel_n) begin
    if (sel_n) n = 0;
    else begin
      sh = {sh[6:0], mosi};
      n++;
    end
  end
  // data out on falling clock; a released line flips so stale bits never match
  initial miso = 1'b0;
  always @(negedge sclk or posedge sel_n) begin
    if (sel_n) miso <= ~miso;
    else if (n % 16 >= 8) begin
      if (n % 16 == 8) dat = (sh == SPI_ADDR_DX) ? dx : dy;
      miso <= dat[15 - n % 16];
    end
  end
endmodule : mic_sensor_model
`default_nettype wire

// file: tb/test_mouse_input_controller.sv
// self-checking bench for the mouse input controller
// assumes the sensor model and the bound checker; short sim counts
`timescale 1ns/1ps
`default_nettype none
module test_mouse_input_controller
  import mic_pkg::*;
;
  localparam int EP = 40;
  logic         clock = 1'b0, srst = 1'b1, active_mode = 1'b0, pa = 1'b0, pb = 1'b0;
  logic         moving = 1'b0, taken = 1'b0, emit, miso, alert, valid, asleep;
  logic [2:0]   button_n = 3'h7, pressed;
  logic [7:0]   sdx = 8'h00, sdy = 8'h00;
  logic [1:0]   ph = 2'h0;
  mic_spi_out_t spi;
  mic_report_t  report;
  int           bad_count = 0, comparisons = 0;
  // rows: dx, dy, wheel steps, buttons held; the report must echo them
  mic_report_t  rows [3] = '{'{8'h05, 8'hFB, 8'h03, 3'h1}, '{8'h80, 8'h7F, 8'hFE, 3'h4},
                             '{8'h00, 8'hFF, 8'h00, 3'h2}};
  mic_input_ctrl #(.EMIT_PERIOD(EP), .EMIT_ON(8), .DEBOUNCE(8), .HALF_BIT(4)) dut_u (
    .clock(clock), .srst(srst), .ce(1'b1), .active_mode(active_mode), .wheel_emitter_on(emit),
    .wheel_phase_a(pa), .wheel_phase_b(pb), .button_n(button_n), .button_pull_en(),
    .buttons_pressed(pressed), .motion_alert(alert), .spi_miso(miso), .spi_out(spi),
    .report(report), .report_valid(valid), .report_taken(taken), .asleep(asleep));
  mic_sensor_model sen_u (.sclk(spi.sclk), .mosi(spi.mosi), .sel_n(spi.sel_n), .miso(miso),
    .moving(moving), .dx(sdx), .dy(sdy), .motion_alert(alert));
  always #10 clock = ~clock;
  task automatic step(int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // d gray steps of the encoder in one jump, held for a whole emitter period
  task automatic turn(int d);
    ph = ph + 2'(d);
    {pb, pa} = {ph[1], ^ph};
    step(EP);
  endtask
  // buttons and wheel, then a motion read; a later dx must not replace a pending report
  task automatic do_read(mic_report_t e);
    int k;
    button_n = ~e.buttons;
    step(20);
    for (k = 0; k < $signed(e.wheel); k++) turn(1);
    for (k = 0; k > $signed(e.wheel); k--) turn(-1);
    sdx = e.dx;
    sdy = e.dy;
    moving = 1'b1;
    for (k = 0; k < 400 && valid !== 1'b1; k++) step(1);
    if (k == 400) begin
      bad_count++;
      complete_run;
    end
    sdx = ~e.dx;
    step(60);
    chk("report", 32'(report), 32'(e));
    moving = 1'b0;
    step(4);
    taken = 1'b1;
    step(1);
    taken = 1'b0;
    chk("report_valid", 32'(valid), 32'h0);
  endtask
  initial begin
    step(20);
    srst = 1'b0;
    step(1);
    chk("idle", 32'({spi.sclk, spi.sel_n, valid, asleep, pressed, emit}), 32'hD0);
    // a press shorter than the debounce time
    button_n[2] = 1'b0;
    step(3);
    button_n[2] = 1'b1;
    active_mode = 1'b1;
    step(EP + 20);
    chk("glitch", 32'(pressed), 32'h0);
    foreach (rows[i]) do_read(rows[i]);
    turn(2);
    do_read('{8'h11, 8'h22, 8'h01, 3'h0});
    active_mode = 1'b0;
    step(5);
    chk("emitter", 32'(emit), 32'h0);
    turn(1);
    srst = 1'b1;
    step(3);
    srst = 1'b0;
    step(1);
    chk("rst", 32'({spi.sclk, spi.sel_n, valid, asleep, pressed, emit}), 32'hD0);
    complete_run;
  end
endmodule : test_mouse_input_controller
`default_nettype wire
